/* lcg2s_defs.vh */
// Constants for the logic cell gate 2 input select block
// Contract
// - Bit 6 gates inverted input 4.
// - Bit 5 gates true input 3.
// - Bit 4 gates inverted input 3.
// - Bit 3 gates true input 2.
// - Bit 2 gates inverted input 2.
// - Bit 1 gates true input 1.
// - Each input picked by six-bit source field.
`ifndef LCG2S_DEFS_VH
`define LCG2S_DEFS_VH

// Register bus widths
`define LCG2S_ADDR_W        4
`define LCG2S_DATA_W        8

// Register offsets
`define LCG2S_OFS_GATE2SEL  4'h0
`define LCG2S_OFS_IN1SRC    4'h1
`define LCG2S_OFS_IN2SRC    4'h2
`define LCG2S_OFS_IN3SRC    4'h3
`define LCG2S_OFS_IN4SRC    4'h4
`define LCG2S_OFS_STATUS    4'h5

// Reset values
`define LCG2S_RST_GATE2SEL  8'h00
`define LCG2S_RST_SRC       6'h00

// Source selection field
`define LCG2S_SRC_W         6
`define LCG2S_SRC_N         64

// Gate 2 select field positions
`define LCG2S_IN1_INV_BIT   0
`define LCG2S_IN1_TRUE_BIT  1
`define LCG2S_IN2_INV_BIT   2
`define LCG2S_IN2_TRUE_BIT  3
`define LCG2S_IN3_INV_BIT   4
`define LCG2S_IN3_TRUE_BIT  5
`define LCG2S_IN4_INV_BIT   6
`define LCG2S_IN4_TRUE_BIT  7

// Status field positions
`define LCG2S_STAT_DATA_LSB 0
`define LCG2S_STAT_GATE_BIT 4

`endif

/* lcg2s_src_sel.v */
// One data input source selector of the logic cell
`timescale 1ns/100ps
`include "lcg2s_defs.vh"

module lcg2s_src_sel (
    // Source list, already synchronised
    input  wire [`LCG2S_SRC_N-1:0] srcBus,
    // Source selection field
    input  wire [`LCG2S_SRC_W-1:0] srcSel,
    // Chosen data input
    output wire                    dataOut
);

    // Pick one line of the source list by the field value
    assign dataOut = srcBus[srcSel];

endmodule

/* lcg2s_top.v */
// Gate 2 input gating stage of a configurable logic cell
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "lcg2s_defs.vh"

module lcg2s_top (
    // Clock and reset
    input  wire                     clk_sys,
    input  wire                     reset_n,
    // Register port
    input  wire [`LCG2S_ADDR_W-1:0] regAddr,
    input  wire [`LCG2S_DATA_W-1:0] regWrData,
    input  wire                     regWrEn,
    input  wire                     regRdEn,
    output reg  [`LCG2S_DATA_W-1:0] regRdData_r,
    // Cell input source list
    input  wire [`LCG2S_SRC_N-1:0]  srcBus,
    // Chosen data inputs, for the later stage
    output reg  [3:0]               dataIn_r,
    // Gate 2 output
    output reg                      secondGateOut_r
);

    // Gate 2 select register, one bit per gated term
    reg  [7:0]                gate2Sel_r;
    // Input source fields, one per data input
    reg  [`LCG2S_SRC_W-1:0]   in1Src_r;
    reg  [`LCG2S_SRC_W-1:0]   in2Src_r;
    reg  [`LCG2S_SRC_W-1:0]   in3Src_r;
    reg  [`LCG2S_SRC_W-1:0]   in4Src_r;
    // Source list synchroniser stages
    reg  [`LCG2S_SRC_N-1:0]   srcMeta_r;
    reg  [`LCG2S_SRC_N-1:0]   srcSync_r;
    // Selected data inputs, combinational
    wire [3:0]                dataSel;
    // Source fields packed for the generate loop
    wire [4*`LCG2S_SRC_W-1:0] srcFields;
    // Individual gated terms and their OR
    reg  [7:0]                gateTerm;
    reg                       gateNxt;
    // Read data next value
    reg  [`LCG2S_DATA_W-1:0]  rdData_nxt;
    // Address decode hits
    wire                      hitGate;
    wire                      hitIn1;
    wire                      hitIn2;
    wire                      hitIn3;
    wire                      hitIn4;
    wire                      hitStat;

    // Address compare, used for every register decode
    // Full-width equality, so no offset aliases another
    function addrHit;
        input [`LCG2S_ADDR_W-1:0] addr;
        input [`LCG2S_ADDR_W-1:0] ofs;
        begin
            addrHit = (addr == ofs);
        end
    endfunction

    // Widen a six-bit source field to a register byte
    function [`LCG2S_DATA_W-1:0] srcByte;
        input [`LCG2S_SRC_W-1:0] fld;
        begin
            srcByte = {2'h0, fld};
        end
    endfunction

    // Register decode
    // At most one hit is high for any offset
    assign hitGate = addrHit(regAddr, `LCG2S_OFS_GATE2SEL);
    assign hitIn1  = addrHit(regAddr, `LCG2S_OFS_IN1SRC);
    assign hitIn2  = addrHit(regAddr, `LCG2S_OFS_IN2SRC);
    assign hitIn3  = addrHit(regAddr, `LCG2S_OFS_IN3SRC);
    assign hitIn4  = addrHit(regAddr, `LCG2S_OFS_IN4SRC);
    assign hitStat = addrHit(regAddr, `LCG2S_OFS_STATUS);

    // Register writes; upper two source bits are not stored
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // Select and source fields come up cleared
            gate2Sel_r <= `LCG2S_RST_GATE2SEL;
            in1Src_r   <= `LCG2S_RST_SRC;
            in2Src_r   <= `LCG2S_RST_SRC;
            in3Src_r   <= `LCG2S_RST_SRC;
            in4Src_r   <= `LCG2S_RST_SRC;
        end else if (regWrEn) begin
            // Gate 2 select byte
            if (hitGate) begin
                gate2Sel_r <= regWrData;
            end
            // Data input source fields; byte bits 7:6 are dropped
            // Input 1 source field
            if (hitIn1) begin
                in1Src_r <= regWrData[`LCG2S_SRC_W-1:0];
            end
            // Input 2 source field
            if (hitIn2) begin
                in2Src_r <= regWrData[`LCG2S_SRC_W-1:0];
            end
            // Input 3 source field
            if (hitIn3) begin
                in3Src_r <= regWrData[`LCG2S_SRC_W-1:0];
            end
            // Input 4 source field
            if (hitIn4) begin
                in4Src_r <= regWrData[`LCG2S_SRC_W-1:0];
            end
            // Status and unmapped offsets ignore writes
        end
    end

    // Read data mux; unmapped offsets and unused bits read zero
    // Status shows the registered outputs, as the later stage sees them
    always @* begin
        rdData_nxt = {`LCG2S_DATA_W{1'b0}};
        if (regRdEn) begin
            if (hitGate) begin
                // Gate 2 select byte as written
                rdData_nxt = gate2Sel_r;
            end else if (hitIn1) begin
                // Source fields, upper two bits zero
                rdData_nxt = srcByte(in1Src_r);
            end else if (hitIn2) begin
                rdData_nxt = srcByte(in2Src_r);
            end else if (hitIn3) begin
                rdData_nxt = srcByte(in3Src_r);
            end else if (hitIn4) begin
                rdData_nxt = srcByte(in4Src_r);
            end else if (hitStat) begin
                // Live data inputs and gate output
                rdData_nxt[`LCG2S_STAT_DATA_LSB+3:`LCG2S_STAT_DATA_LSB] =
                    dataIn_r;
                rdData_nxt[`LCG2S_STAT_GATE_BIT] = secondGateOut_r;
            end else begin
                // Unmapped offsets
                rdData_nxt = {`LCG2S_DATA_W{1'b0}};
            end
        end
    end

    // Read data register, valid only the cycle after the strobe
    // Returns to zero in every cycle without a read
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            regRdData_r <= {`LCG2S_DATA_W{1'b0}};
        end else begin
            regRdData_r <= rdData_nxt;
        end
    end

    // Two-stage synchroniser for the source list, which may hold pins
    // The first stage may go metastable; only the second is read
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            srcMeta_r <= {`LCG2S_SRC_N{1'b0}};
            srcSync_r <= {`LCG2S_SRC_N{1'b0}};
        end else begin
            srcMeta_r <= srcBus;
            srcSync_r <= srcMeta_r;
        end
    end

    // Pack the source fields, input 1 in the low slice
    // Slice n-1 feeds data input n
    assign srcFields = {in4Src_r, in3Src_r, in2Src_r, in1Src_r};

    // One source selector per data input
    // Each selector reads only the second synchroniser stage
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : gSrc
            lcg2s_src_sel uSel (
                .srcBus  (srcSync_r),
                .srcSel  (srcFields[gi*`LCG2S_SRC_W +: `LCG2S_SRC_W]),
                .dataOut (dataSel[gi])
            );
        end
    endgenerate

    // Gated terms: each select bit passes one true or inverted input
    // A select write reaches the gate output one edge later
    always @* begin
        gateTerm = 8'h00;
        // Input 4, true and inverted
        gateTerm[`LCG2S_IN4_TRUE_BIT] =
            gate2Sel_r[`LCG2S_IN4_TRUE_BIT] & dataSel[3];
        gateTerm[`LCG2S_IN4_INV_BIT] =
            gate2Sel_r[`LCG2S_IN4_INV_BIT] & ~dataSel[3];
        // Input 3, true and inverted
        gateTerm[`LCG2S_IN3_TRUE_BIT] =
            gate2Sel_r[`LCG2S_IN3_TRUE_BIT] & dataSel[2];
        gateTerm[`LCG2S_IN3_INV_BIT] =
            gate2Sel_r[`LCG2S_IN3_INV_BIT] & ~dataSel[2];
        // Input 2, true and inverted
        gateTerm[`LCG2S_IN2_TRUE_BIT] =
            gate2Sel_r[`LCG2S_IN2_TRUE_BIT] & dataSel[1];
        gateTerm[`LCG2S_IN2_INV_BIT] =
            gate2Sel_r[`LCG2S_IN2_INV_BIT] & ~dataSel[1];
        // Input 1, true and inverted
        gateTerm[`LCG2S_IN1_TRUE_BIT] =
            gate2Sel_r[`LCG2S_IN1_TRUE_BIT] & dataSel[0];
        gateTerm[`LCG2S_IN1_INV_BIT] =
            gate2Sel_r[`LCG2S_IN1_INV_BIT] & ~dataSel[0];
        // Gate combines the passed terms; no term gives zero
        gateNxt = |gateTerm;
    end

    // Registered gate output and chosen inputs
    // Registering keeps the outputs free of decode glitches
    // Chosen inputs and gate output move on the same edge
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // Outputs idle low through reset
            dataIn_r        <= 4'h0;
            secondGateOut_r <= 1'b0;
        end else begin
            dataIn_r        <= dataSel;
            secondGateOut_r <= gateNxt;
        end
    end

endmodule

/* lcg2s_props.sv */
// Checker of gate 2 term gating and source routing
`timescale 1ns/100ps
module lcg2s_props (
    // Clock and reset
    input wire        clk_sys,
    input wire        reset_n,
    // Register port
    input wire [3:0]  regAddr,
    input wire [7:0]  regWrData,
    input wire        regWrEn,
    input wire        regRdEn,
    input wire [7:0]  regRdData_r,
    // Gate path
    input wire [63:0] srcBus,
    input wire [3:0]  dataIn_r,
    input wire        secondGateOut_r
);
    reg [7:0]  gs_r, gd_r;        // Shadow select, and one edge late
    reg [23:0] sf_r, sd_r;        // Shadow source fields, and late
    reg [63:0] p1_r, p2_r, p3_r;  // Source bus history
    // Terms as the gate sees them, bit order of the select
    wire [7:0] t = {dataIn_r[3], ~dataIn_r[3], dataIn_r[2], ~dataIn_r[2],
                    dataIn_r[1], ~dataIn_r[1], dataIn_r[0], ~dataIn_r[0]};
    wire [3:0] eIn = {p3_r[sd_r[23:18]], p3_r[sd_r[17:12]],
                      p3_r[sd_r[11:6]], p3_r[sd_r[5:0]]};
    // Mirror writes; outputs use values one edge old
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            {gs_r, gd_r, sf_r, sd_r} <= 64'h0;
            {p1_r, p2_r, p3_r} <= 192'h0;
        end else begin
            gd_r <= gs_r;
            sd_r <= sf_r;
            {p1_r, p2_r, p3_r} <= {srcBus, p1_r, p2_r};
            if (regWrEn && regAddr == 4'h0)
                gs_r <= regWrData;
            if (regWrEn && regAddr >= 4'h1 && regAddr <= 4'h4)
                sf_r[(regAddr - 4'h1) * 6 +: 6] <= regWrData[5:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    in4_inv_a: assert property (gd_r[6] && t[6] |-> secondGateOut_r)
        else $error("in4 inverted term lost");
    in3_true_a: assert property (
        gd_r[5] && t[5] |-> secondGateOut_r)
        else $error("in3 true term lost");
    in3_inv_a: assert property (gd_r[4] && t[4] |-> secondGateOut_r)
        else $error("in3 inverted term lost");
    in2_true_a: assert property (
        gd_r[3] && t[3] |-> secondGateOut_r)
        else $error("in2 true term lost");
    in2_inv_a: assert property (gd_r[2] && t[2] |-> secondGateOut_r)
        else $error("in2 inverted term lost");
    in1_true_a: assert property (
        gd_r[1] && t[1] |-> secondGateOut_r)
        else $error("in1 true term lost");
    edge_terms_a: assert property (
        |(gd_r & t & 8'h81) |-> secondGateOut_r)
        else $error("in4 true or in1 inverted term lost");
    gate_off_a: assert property (secondGateOut_r |-> |(gd_r & t))
        else $error("gate high with no enabled term");
    src_route_a: assert property (dataIn_r == eIn)
        else $error("data input from wrong source");
    cover property (secondGateOut_r);
    cover property (regRdEn && regAddr == 4'h0);
    cover property ($rose(dataIn_r[3]));
endmodule

bind lcg2s_top lcg2s_props u_props (.clk_sys, .reset_n, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData_r, .srcBus, .dataIn_r,
    .secondGateOut_r);

/* lcg2s_top_tb.sv */
// Self-checking bench of the gate 2 input select block
`timescale 1ns/100ps
module lcg2s_top_tb;
    reg         clk_sys = 1'b0;
    reg         reset_n = 1'b0;
    reg  [3:0]  regAddr = 4'h0;
    reg  [7:0]  regWrData = 8'h00;
    reg         regWrEn = 1'b0;
    reg         regRdEn = 1'b0;
    reg  [63:0] srcBus = 64'h0;
    wire [7:0]  regRdData_r;
    wire [3:0]  dataIn_r;
    wire        secondGateOut_r;
    integer     nFail = 0, checksDone = 0, cyc = 0, v;
    reg  [7:0]  t;
    reg  [63:0] b;
    lcg2s_top u_dut (.clk_sys, .reset_n, .regAddr, .regWrData, .regWrEn,
        .regRdEn, .regRdData_r, .srcBus, .dataIn_r, .secondGateOut_r);
    // Clock of 50 ns
    initial forever #25 clk_sys = ~clk_sys;
    // Cut a hang short
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            nFail = nFail + 1;
            finishTest;
        end
    end
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            checksDone = checksDone + 1;
            if (got !== exp) begin
                nFail = nFail + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            regWrEn <= 1'b1;
            regAddr <= a;
            regWrData <= d;
            @(posedge clk_sys);
            regWrEn <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] e);
        begin
            @(posedge clk_sys);
            regRdEn <= 1'b1;
            regAddr <= a;
            @(posedge clk_sys);
            regRdEn <= 1'b0;
            #1 cmp(regRdData_r, e);
        end
    endtask
    // One select value against all sixteen input patterns
    task sweep(input [7:0] s);
        begin
            wr(4'h0, s);
            rd(4'h0, s);
            for (v = 0; v < 16; v = v + 1) begin
                // Unused sources carry the inverse pattern
                b = {16{~v[3:0]}};
                b[63] = v[0];
                b[33] = v[1];
                b[16] = v[2];
                b[5] = v[3];
                @(posedge clk_sys);
                srcBus <= b;
                repeat (4) @(posedge clk_sys);
                t = {v[3], ~v[3], v[2], ~v[2], v[1], ~v[1], v[0], ~v[0]};
                #1 cmp({3'h0, secondGateOut_r, dataIn_r},
                    {3'h0, |(s & t), v[3:0]});
            end
        end
    endtask
    task finishTest;
        begin
            $display("Checks %0d, mismatches %0d", checksDone, nFail);
            if (nFail == 0 && checksDone > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(4'h0, 8'h00);
        // Sources 63, 33, 16, 5 for inputs 1 to 4
        wr(4'h1, 8'hff);
        wr(4'h2, 8'h21);
        wr(4'h3, 8'h10);
        wr(4'h4, 8'h05);
        wr(4'h6, 8'h5a);
        rd(4'h1, 8'h3f);
        rd(4'h4, 8'h05);
        // Read data falls back to zero the cycle after
        @(posedge clk_sys);
        #1 cmp(regRdData_r, 8'h00);
        rd(4'h6, 8'h00);
        // Each select bit alone, then none, then all
        sweep(8'h40);
        sweep(8'h20);
        sweep(8'h10);
        sweep(8'h08);
        sweep(8'h04);
        sweep(8'h02);
        sweep(8'h80);
        sweep(8'h01);
        sweep(8'h00);
        sweep(8'hff);
        rd(4'h5, 8'h1f);
        finishTest;
    end
endmodule
